// file: hdl/hsoc_pkg.sv
/*
 hsoc_pkg: constants, register map and carrier types for the line-sync
 regeneration and coast block.
 assumes: used by hsoc_top and hsoc_phase_delay; no imports.
*/
package hsoc_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_PLL_DIV_MSB = 8'h01;
    localparam logic [7:0] IDX_PLL_DIV_LSB = 8'h02;
    localparam logic [7:0] IDX_PHASE = 8'h04;
    localparam logic [7:0] IDX_SYNC_WIDTH = 8'h07;
    localparam logic [7:0] IDX_SYNC_CTRL = 8'h10;
    localparam logic [7:0] IDX_COAST_CTRL = 8'h11;
    localparam logic [7:0] IDX_STATUS = 8'h20;
    // field positions
    localparam int PHASE_LSB = 3;
    localparam int PHASE_W = 5;
    localparam int DIVLSB_LSB = 4;
    localparam int OUT_POL_BIT = 5;
    localparam int IN_POL_BIT = 6;
    localparam int AUTO_POL_BIT = 7;
    localparam int COAST_LSB = 1;
    localparam int COAST_W = 3;
    // reset values
    localparam logic [7:0] RST_DIV_MSB = 8'h69;
    localparam logic [7:0] RST_DIV_LSB = 8'hD0;
    localparam logic [7:0] RST_PHASE = 8'h80;
    localparam logic [7:0] RST_SYNC_WIDTH = 8'h20;
    localparam logic [7:0] RST_SYNC_CTRL = 8'h80;
    localparam logic [7:0] RST_COAST_CTRL = 8'h0E;
    // phase steps per full cycle
    localparam int PHASE_STEPS = 32;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic sync;
        logic coast;
        logic ref_gate;
    } hsoc_sync_t;
endpackage : hsoc_pkg

// file: hdl/hsoc_phase_delay.sv
/*
 hsoc_phase_delay: shifts a sampled sync level by a programmable number of
 fine steps; one full cycle is split into PHASE_STEPS taps.
 assumes: a pixel-rate clock with PHASE_STEPS-times oversampled input.
*/
`timescale 1ns/1ps
module hsoc_phase_delay #(
    parameter int STEPS = hsoc_pkg::PHASE_STEPS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sync_in,
    input wire logic [$clog2(STEPS)-1:0] phase,
    output logic sync_out
);
    logic [STEPS-1:0] taps;
    wire logic tapped;

    // tap line shifting one position per edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            taps <= '0;
        else
            taps <= {taps[STEPS-2:0], sync_in};
    end

    assign tapped = taps[phase];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sync_out <= 1'b0;
        else
            sync_out <= tapped;
    end
endmodule : hsoc_phase_delay

// file: hdl/hsoc_top.sv
/*
 hsoc_top: line-sync polarity detect, phase shift, regeneration with
 programmable width and polarity, coast generation gating the pll ref.
 assumes: aclk is the pixel clock; sync inputs are asynchronous pins;
 software reaches registers over axi4-lite.
*/
`timescale 1ns/1ps
module hsoc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic line_sync_in,
    input wire logic frame_sync_in,
    input wire logic [23:0] pixel_in,
    output logic regenerated_line_sync_out,
    output logic output_pixel_clock,
    output logic [23:0] pixel_out,
    output logic pll_ref_out,
    output logic coast_out,
    output logic pll_cmp_pulse,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    function automatic logic [5:0] word_index(input logic [7:0] addr);
        word_index = addr[7:2];
    endfunction : word_index

    function automatic logic known_index(input logic [5:0] idx);
        known_index = (idx == 6'(hsoc_pkg::IDX_PLL_DIV_MSB))
            || (idx == 6'(hsoc_pkg::IDX_PLL_DIV_LSB))
            || (idx == 6'(hsoc_pkg::IDX_PHASE))
            || (idx == 6'(hsoc_pkg::IDX_SYNC_WIDTH))
            || (idx == 6'(hsoc_pkg::IDX_SYNC_CTRL))
            || (idx == 6'(hsoc_pkg::IDX_COAST_CTRL))
            || (idx == 6'(hsoc_pkg::IDX_STATUS));
    endfunction : known_index

    logic [7:0] reg_div_msb, reg_div_lsb, reg_phase, reg_width;
    logic [7:0] reg_sync_ctrl, reg_coast_ctrl;

    // write channel capture
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire logic aw_take = s_axi_awvalid && s_axi_awready;
    wire logic w_take = s_axi_wvalid && s_axi_wready;
    wire logic do_write = aw_held && w_held && !s_axi_bvalid;
    wire logic [5:0] w_idx = word_index(aw_addr);
    wire logic w_ok = known_index(w_idx)
        && (w_idx != 6'(hsoc_pkg::IDX_STATUS));
    wire logic w_lane0 = do_write && w_ok && w_strb[0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= hsoc_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
            s_axi_wready <= !w_held && !w_take && !s_axi_bvalid;
            if (aw_take)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= w_ok ? hsoc_pkg::RESP_OKAY
                    : hsoc_pkg::RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // register file, low byte lane only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            reg_div_msb <= hsoc_pkg::RST_DIV_MSB;
            reg_div_lsb <= hsoc_pkg::RST_DIV_LSB;
            reg_phase <= hsoc_pkg::RST_PHASE;
            reg_width <= hsoc_pkg::RST_SYNC_WIDTH;
            reg_sync_ctrl <= hsoc_pkg::RST_SYNC_CTRL;
            reg_coast_ctrl <= hsoc_pkg::RST_COAST_CTRL;
        end
        else if (w_lane0)
        begin
            if (w_idx == 6'(hsoc_pkg::IDX_PLL_DIV_MSB))
                reg_div_msb <= w_data[7:0];
            if (w_idx == 6'(hsoc_pkg::IDX_PLL_DIV_LSB))
                reg_div_lsb <= {w_data[7:4], 4'h0};
            if (w_idx == 6'(hsoc_pkg::IDX_PHASE))
                reg_phase <= {w_data[7:3], 3'h0};
            if (w_idx == 6'(hsoc_pkg::IDX_SYNC_WIDTH))
                reg_width <= w_data[7:0];
            if (w_idx == 6'(hsoc_pkg::IDX_SYNC_CTRL))
                reg_sync_ctrl <= w_data[7:0];
            if (w_idx == 6'(hsoc_pkg::IDX_COAST_CTRL))
                reg_coast_ctrl <= w_data[7:0];
        end
    end

    // pin synchronisers
    logic [1:0] ls_sync, fs_sync;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ls_sync <= 2'b00;
            fs_sync <= 2'b00;
        end
        else
        begin
            ls_sync <= {ls_sync[0], line_sync_in};
            fs_sync <= {fs_sync[0], frame_sync_in};
        end
    end
    wire logic ls_pin = ls_sync[1];
    wire logic fs_pin = fs_sync[1];

    logic [11:0] high_cnt, low_cnt;
    logic det_pol_high, ls_pin_d;
    wire logic ls_edge = ls_pin != ls_pin_d;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ls_pin_d <= 1'b0;
            high_cnt <= 12'h000;
            low_cnt <= 12'h000;
            det_pol_high <= 1'b1;
        end
        else
        begin
            ls_pin_d <= ls_pin;
            if (ls_pin && high_cnt != 12'hFFF)
                high_cnt <= high_cnt + 12'h001;
            if (!ls_pin && low_cnt != 12'hFFF)
                low_cnt <= low_cnt + 12'h001;
            if (ls_edge && !ls_pin)
            begin
                det_pol_high <= high_cnt < low_cnt;
                high_cnt <= 12'h000;
                low_cnt <= 12'h000;
            end
        end
    end

    // manual polarity when auto is off
    wire logic in_active_high = reg_sync_ctrl[hsoc_pkg::AUTO_POL_BIT]
        ? det_pol_high : reg_sync_ctrl[hsoc_pkg::IN_POL_BIT];
    wire logic ls_norm = ls_pin ~^ in_active_high;

    logic ls_shift;
    hsoc_phase_delay #(.STEPS(hsoc_pkg::PHASE_STEPS)) hsoc_phase_delay_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .sync_in(ls_norm),
        .phase(reg_phase[hsoc_pkg::PHASE_LSB +: hsoc_pkg::PHASE_W]),
        .sync_out(ls_shift)
    );

    logic ls_shift_d;
    logic [7:0] width_left;
    wire logic lead_edge = ls_shift && !ls_shift_d;
    wire logic pulse_on = lead_edge || (width_left != 8'h00);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ls_shift_d <= 1'b0;
            width_left <= 8'h00;
        end
        else
        begin
            ls_shift_d <= ls_shift;
            if (lead_edge)
                width_left <= (reg_width == 8'h00) ? 8'h00
                    : reg_width - 8'h01;
            else if (width_left != 8'h00)
                width_left <= width_left - 8'h01;
        end
    end
    wire logic pulse_lvl = pulse_on && (reg_width != 8'h00);

    // coast from frame sync, gating pll reference
    wire logic coast_en = reg_coast_ctrl[hsoc_pkg::COAST_LSB +:
        hsoc_pkg::COAST_W] != 3'h0;
    wire logic next_coast = coast_en && fs_pin;
    wire logic next_ref = ls_norm && !next_coast;

    wire logic [11:0] divisor = {reg_div_msb,
        reg_div_lsb[hsoc_pkg::DIVLSB_LSB +: 4]};
    logic [11:0] div_cnt;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_cnt <= 12'h000;
            pll_cmp_pulse <= 1'b0;
        end
        else
        begin
            pll_cmp_pulse <= div_cnt == divisor;
            div_cnt <= (div_cnt == divisor) ? 12'h000 : div_cnt + 12'h001;
        end
    end

    // output registers
    logic clk_phase;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            regenerated_line_sync_out <= 1'b0;
            output_pixel_clock <= 1'b0;
            clk_phase <= 1'b0;
            pixel_out <= 24'h000000;
            pll_ref_out <= 1'b0;
            coast_out <= 1'b0;
        end
        else
        begin
            clk_phase <= !clk_phase;
            // clock rises mid data, data moves on low phase
            output_pixel_clock <= !clk_phase;
            if (clk_phase)
                pixel_out <= pixel_in;
            if (clk_phase)
                regenerated_line_sync_out <= pulse_lvl
                    ~^ reg_sync_ctrl[hsoc_pkg::OUT_POL_BIT];
            pll_ref_out <= next_ref;
            coast_out <= next_coast;
        end
    end

    // status shows coast and polarity for software
    wire logic [5:0] r_idx = word_index(s_axi_araddr);
    logic [7:0] r_byte;
    always_comb
    begin
        r_byte = 8'h00;
        case (r_idx)
            6'(hsoc_pkg::IDX_PLL_DIV_MSB): r_byte = reg_div_msb;
            6'(hsoc_pkg::IDX_PLL_DIV_LSB): r_byte = reg_div_lsb;
            6'(hsoc_pkg::IDX_PHASE): r_byte = reg_phase;
            6'(hsoc_pkg::IDX_SYNC_WIDTH): r_byte = reg_width;
            6'(hsoc_pkg::IDX_SYNC_CTRL): r_byte = reg_sync_ctrl;
            6'(hsoc_pkg::IDX_COAST_CTRL): r_byte = reg_coast_ctrl;
            6'(hsoc_pkg::IDX_STATUS):
                r_byte = {5'h00, coast_out, ls_norm, det_pol_high};
            default: r_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= hsoc_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready
                && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, r_byte};
                s_axi_rresp <= known_index(r_idx) ? hsoc_pkg::RESP_OKAY
                    : hsoc_pkg::RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule : hsoc_top

// file: dv/hsoc_checker.sv
/* hsoc_checker: port properties of hsoc_top.
 assumes: bound into hsoc_top; one clock, sync active-low reset. */
`timescale 1ns/1ps
module hsoc_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic regenerated_line_sync_out,
    input wire logic output_pixel_clock,
    input wire logic [23:0] pixel_out,
    input wire logic pll_ref_out,
    input wire logic coast_out,
    input wire logic pll_cmp_pulse,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_ref_gated: assert property (coast_out [*2] |-> !pll_ref_out)
        else $error("pll reference passed during coast");
    a_clk_toggle: assert property ($past(aresetn) |->
        output_pixel_clock != $past(output_pixel_clock))
        else $error("output clock missed a toggle");
    a_data_on_fall: assert property ($past(aresetn, 2) &&
        $changed(pixel_out) |-> $fell(output_pixel_clock))
        else $error("pixel data moved off the falling clock");
    a_sync_on_fall: assert property ($past(aresetn, 2) &&
        $changed(regenerated_line_sync_out) |-> $fell(output_pixel_clock))
        else $error("line sync moved off the data cadence");
    a_cmp_gap: assert property (pll_cmp_pulse |=> !pll_cmp_pulse [*8])
        else $error("compare pulses too close");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready |->
        ##[1:4] s_axi_bvalid)
        else $error("write answer late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    c_coast: cover property ($rose(coast_out));
    c_sync: cover property ($changed(regenerated_line_sync_out));
    c_cmp: cover property (pll_cmp_pulse ##1 !pll_cmp_pulse);
endmodule : hsoc_checker
bind hsoc_top hsoc_checker hsoc_checker_i (.aclk(aclk), .aresetn(aresetn),
    .regenerated_line_sync_out(regenerated_line_sync_out),
    .output_pixel_clock(output_pixel_clock), .pixel_out(pixel_out),
    .pll_ref_out(pll_ref_out), .coast_out(coast_out),
    .pll_cmp_pulse(pll_cmp_pulse), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

// file: dv/hsoc_display_model.sv
/* hsoc_display_model: display logic latching pixels and line sync on
 rising output clock edges.
 assumes: output clock slower than aclk; cyc is a free cycle count. */
`timescale 1ns/1ps
module hsoc_display_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic output_pixel_clock,
    input wire logic [23:0] pixel_out,
    input wire logic line_sync,
    input wire logic active_high,
    input wire logic [31:0] cyc,
    output logic [23:0] latched_pixel,
    output logic [7:0] pulse_len,
    output logic [31:0] pulse_at,
    output logic [7:0] pulse_count
);
    logic clk_d, act_d;
    logic [7:0] run;
    wire logic act = line_sync == active_high;
    wire logic clk_rise = output_pixel_clock && !clk_d;
    always_ff @(posedge aclk)
    begin
        clk_d <= output_pixel_clock;
        act_d <= act;
        if (act && !act_d) pulse_at <= cyc;
        if (clk_rise) latched_pixel <= pixel_out;
        if (clk_rise && act) run <= run + 8'h1;
        else if (clk_rise && run != 8'h0)
        begin
            pulse_len <= {run[6:0], 1'b0};
            pulse_count <= pulse_count + 8'h1;
            run <= 8'h0;
        end
        if (!aresetn)
        begin
            run <= 8'h0;
            pulse_count <= 8'h0;
            pulse_len <= 8'h0;
        end
    end
endmodule : hsoc_display_model

// file: dv/hsoc_test.sv
/* hsoc_test: self-checking bench for hsoc_top with a display model.
 assumes: design, model and checker compiled first. */
`timescale 1ns/1ps
module hsoc_test;
    logic aclk, aresetn, line_sync_in, frame_sync_in, in_act, out_pol;
    logic [23:0] pixel_in, pixel_out, latched_pixel;
    logic regenerated_line_sync_out, output_pixel_clock, pll_ref_out;
    logic coast_out, pll_cmp_pulse, s_axi_rready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr, pulse_len, pulse_count;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic [31:0] s_axi_wdata, s_axi_rdata, pulse_at;
    logic [31:0] cyc = 32'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb;
    int err_count, n_compared;
    hsoc_top hsoc_top_i (.*);
    hsoc_display_model hsoc_display_model_i (.aclk(aclk), .aresetn(aresetn),
        .output_pixel_clock(output_pixel_clock), .pixel_out(pixel_out),
        .line_sync(regenerated_line_sync_out), .active_high(out_pol),
        .cyc(cyc), .latched_pixel(latched_pixel), .pulse_len(pulse_len),
        .pulse_at(pulse_at), .pulse_count(pulse_count));
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // line sync source, active for the short phase
    always @(posedge aclk)
    begin
        cyc <= cyc + 32'h1;
        pixel_in <= cyc[23:0];
        line_sync_in <= (cyc % 200 < 20) ? in_act : !in_act;
    end
    task automatic complete_run;
        $display("compared %0d mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic timed_out;
        err_count++;
        $display("[FAIL] %0t wait expired got %h exp %h", $time, 0, 1);
        complete_run();
    endtask : timed_out
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
        input logic [1:0] er);
        int i;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (i = 0; i < 60; i++)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            if (i == 3) s_axi_bready <= 1'b1;
        end
        s_axi_bready <= 1'b0;
        if (i == 60) timed_out();
        chk(s_axi_bresp, er);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int i;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (i = 0; i < 60; i++)
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            if (i == 3) s_axi_rready <= 1'b1;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (i == 60) timed_out();
    endtask : rd
    task automatic wait_line;
        logic [7:0] c;
        int i;
        c = pulse_count;
        for (i = 0; i < 400 && pulse_count == c; i++) @(posedge aclk);
        if (i == 400) timed_out();
    endtask : wait_line
    task automatic wait_cmp(output int n);
        for (n = 1; n < 5000; n++)
        begin
            @(posedge aclk);
            if (pll_cmp_pulse) break;
        end
        if (n == 5000) timed_out();
    endtask : wait_cmp
    task automatic t_regs;
        logic [7:0] a [6] = '{8'h04, 8'h08, 8'h10, 8'h1C, 8'h40, 8'h44};
        logic [7:0] e [6] = '{8'h69, 8'hD0, 8'h80, 8'h20, 8'h80, 8'h0E};
        logic [31:0] d;
        logic [1:0] r;
        for (int k = 0; k < 6; k++)
        begin
            rd(a[k], d, r);
            chk(d, {24'h0, e[k]});
        end
        rd(8'hFC, d, r);
        chk({r, d[29:0]}, {hsoc_pkg::RESP_SLVERR, 30'h0});
        wr(8'h80, 8'hFF, hsoc_pkg::RESP_SLVERR);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_sync(input logic [7:0] w, input logic p, input logic ia,
        input logic au);
        in_act <= ia;
        out_pol <= p;
        wr(8'h1C, w, hsoc_pkg::RESP_OKAY);
        wr(8'h40, {au, ia, p, 5'h0}, hsoc_pkg::RESP_OKAY);
        repeat (800) @(posedge aclk);
        wait_line();
        chk(pulse_len, w);
        chk(cyc[23:0] - latched_pixel < 24'd16, 1);
        $display("t_sync done");
    endtask : t_sync
    task automatic t_phase;
        int d0, d1;
        wr(8'h10, 8'h00, hsoc_pkg::RESP_OKAY);
        repeat (400) @(posedge aclk);
        wait_line();
        d0 = pulse_at % 200;
        wr(8'h10, 8'hF8, hsoc_pkg::RESP_OKAY);
        repeat (400) @(posedge aclk);
        wait_line();
        d1 = pulse_at % 200 - d0;
        chk(d1 >= 30 && d1 <= 32, 1);
        $display("t_phase done");
    endtask : t_phase
    task automatic t_coast;
        logic seen;
        logic [31:0] d;
        logic [1:0] r;
        for (int c = 0; c < 2; c++)
        begin
            if (c == 1) wr(8'h44, 8'h00, hsoc_pkg::RESP_OKAY);
            for (int v = 1; v >= 0; v--)
            begin
                frame_sync_in <= v[0];
                repeat (8) @(posedge aclk);
                chk(coast_out, v[0] && c == 0);
                rd(8'h80, d, r);
                chk({r, d[2], d[0]}, {2'h0, v[0] && c == 0, 1'b0});
                seen = 1'b0;
                repeat (400) @(posedge aclk) seen |= pll_ref_out;
                chk(seen, !(v[0] && c == 0));
            end
        end
        wr(8'h44, 8'h0E, hsoc_pkg::RESP_OKAY);
        $display("t_coast done");
    endtask : t_coast
    task automatic t_div(input logic [11:0] v);
        int n;
        wr(8'h04, v[11:4], hsoc_pkg::RESP_OKAY);
        wr(8'h08, {v[3:0], 4'h0}, hsoc_pkg::RESP_OKAY);
        repeat (3) wait_cmp(n);
        chk(n, v + 1);
        $display("t_div done");
    endtask : t_div
    initial
    begin
        {aresetn, frame_sync_in, in_act, out_pol} = 4'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        err_count = 0;
        n_compared = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        t_regs();
        t_sync(8'h04, 1'b1, 1'b0, 1'b1);
        t_sync(8'h08, 1'b0, 1'b1, 1'b1);
        t_sync(8'h06, 1'b0, 1'b0, 1'b0);
        t_phase();
        t_coast();
        t_div(12'h12C);
        t_div(12'hFFF);
        complete_run();
    end
endmodule : hsoc_test
